// File: asc_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module asc_asserts
  import asc_pkg::*;
#(
  parameter int unsigned DATA_PERIOD_CYC = ASC_DATA_PERIOD_CYC
) (
  input wire logic        clk,                  // Master clock
  input wire logic        rst_n,                // Synchronous reset, active low
  input wire logic        sync_pin,             // Sync input
  input wire logic        reset_pin_n,          // Reset pin
  input wire logic        power_down_pin_n,     // Power-down pin
  input wire logic        cmd_valid,            // Command strobe
  input wire asc_cmd_type cmd_code,             // Command opcode
  input wire logic        data_ready_strobe_n,  // Data ready, active low
  input wire logic        dout_forced_low       // Serial data held low
);
  localparam int SETTLE_MIN = DATA_PERIOD_CYC * 16123 / 256 + 460;
  logic        cont_q, cont_d, stby_q, stby_d, hard;
  logic [31:0] cnt_q, cnt_d;
  logic [3:0]  hi_q, hi_d;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Track mode, standby, time held low and strobe high run outside standby
  always_comb begin
    hard = !reset_pin_n || !power_down_pin_n || (cmd_valid && cmd_code == CMD_RESET);
    cont_d = cont_q;
    stby_d = stby_q;
    if (cmd_valid && cmd_code == CMD_CONT_MODE) cont_d = 1'b1;
    if (cmd_valid && cmd_code == CMD_PULSE_MODE) cont_d = 1'b0;
    if (cmd_valid && cmd_code == CMD_STANDBY) stby_d = 1'b1;
    if (cmd_valid && cmd_code == CMD_WAKEUP) stby_d = 1'b0;
    if (hard) cont_d = 1'b0;
    if (hard) stby_d = 1'b0;
    cnt_d = dout_forced_low ? cnt_q + 32'h1 : 32'h0;
    hi_d = (!data_ready_strobe_n || stby_q) ? 4'h0 : ((hi_q == 4'hf) ? hi_q : hi_q + 4'h1);
  end

  // Register the tracking state
  always_ff @(posedge clk) begin
    {cont_q, stby_q, cnt_q, hi_q} <= rst_n ? {cont_d, stby_d, cnt_d, hi_d} : '0;
  end

  a_reset_idle: assert property ($rose(rst_n) |-> (data_ready_strobe_n && dout_forced_low)[*8])
    else $error("outputs not idle after reset");
  a_data_with_strobe: assert property ($fell(dout_forced_low) |-> $fell(data_ready_strobe_n))
    else $error("data released apart from strobe");
  a_settle_min: assert property ($fell(dout_forced_low) |-> cnt_q >= 32'(SETTLE_MIN))
    else $error("filter settled too early");
  a_pulse_restart: assert property ($rose(sync_pin) && !cont_q && !stby_q |->
    ##4 (dout_forced_low && data_ready_strobe_n)[*8]) else $error("pulse sync ignored");
  a_cont_toggles: assert property (cont_q && !stby_q |-> hi_q <= 4'h6)
    else $error("strobe stopped in continuous mode");
  a_reset_pin_acts: assert property ($fell(reset_pin_n) |->
    ##5 (dout_forced_low && data_ready_strobe_n)[*4]) else $error("reset pin ignored");
  a_power_down_pin_n_idle: assert property (!power_down_pin_n[*6] |-> data_ready_strobe_n && dout_forced_low)
    else $error("outputs active in power-down");
  a_cmd_reset: assert property (cmd_valid && cmd_code == CMD_RESET |=>
    ##[0:1] (dout_forced_low && data_ready_strobe_n)) else $error("reset command late");
  a_standby_park: assert property (cmd_valid && cmd_code == CMD_STANDBY |=>
    ##1 data_ready_strobe_n[*8]) else $error("strobe active in standby");
  a_run_period: assert property ($rose(data_ready_strobe_n) && !dout_forced_low |->
    data_ready_strobe_n[*4] ##1 (!data_ready_strobe_n || dout_forced_low || stby_q))
    else $error("strobe high phase wrong");

  c_settled: cover property ($fell(dout_forced_low));
  c_cont_sync: cover property ($rose(sync_pin) && cont_q);
  c_wake: cover property (cmd_valid && cmd_code == CMD_WAKEUP);
endmodule : asc_asserts
`default_nettype wire

// File: asc_device.sv
// Functional notes
// - Resync on edge after sync rise or opcode
// - Pulse sync restarts filter, strobe held high
// - Continuous single sync: strobe toggles, data low
// - Period mismatch against data period forces resync
// - Pulse-mode sync outside standby restarts filter, 63 readings lost
// - First sync clock edge resyncs, matches run free
// - Strobe phase set by initial delay only
// - Host starts sync clock after mode configured
// - Host holds sync phases two clocks minimum
// - Sync data ready after 62.98 periods+466
// - Reset pin low two clocks, held meanwhile
// - Reset command acts on next clock edge
// - Reset restores defaults and resyncs conversions
// - Reset release data ready 62.98 periods+468
// - Power-down pin disables circuitry, clears registers
// - Outputs stay driven during power-down
// - Standby keeps registers and command port alive
// - Supply detectors combined, 2^16 cycle counter
// - Defaults are FIR at 1000 SPS
// - Wake-up delay two clocks shorter than release
// - Wake-up timed from command decode edge
`timescale 1ns/1ps
`default_nettype none
module asc_device
  import asc_pkg::*;
#(
  parameter int unsigned DATA_PERIOD_CYC = ASC_DATA_PERIOD_CYC,
  parameter int unsigned POR_CYC         = ASC_POR_CYC
) (
  input  wire logic       clk,          // Master clock
  input  wire logic       rst_n,        // Synchronous reset, active low
  asc_if.dev              link,         // Pins and commands from host
  input  wire logic       supply_a_ok,  // Analog supply above threshold
  input  wire logic       supply_d_ok,  // Digital supply above threshold
  output logic            converting,   // New data being produced
  output logic            settling,     // Filter restarting
  output logic            standby,      // Standby entered by command
  output logic            cont_mode,    // Continuous-sync mode set
  output logic [2:0]      rate_code,    // Output rate setting
  output logic            por_busy      // Internal power-on reset held
);
  localparam logic [31:0] SYNC_DLY = asc_dr_cyc(DATA_PERIOD_CYC, ASC_SYNC_EXTRA_CYC);
  localparam logic [31:0] RST_DLY  = asc_dr_cyc(DATA_PERIOD_CYC, ASC_RST_EXTRA_CYC);
  localparam logic [31:0] WAKE_DLY = asc_dr_cyc(DATA_PERIOD_CYC,
                                       ASC_RST_EXTRA_CYC - ASC_WAKE_SHORT_CYC);
  localparam logic [31:0] STROBE_HI = 32'(DATA_PERIOD_CYC - ASC_UPDATE_CYC);

  // Synchroniser stages and edge memory
  logic [3:0]    meta_q, meta_d;
  logic [3:0]    pin_q, pin_d;
  logic          sync_prev_q, sync_prev_d;
  logic          sync_rise;

  // Power-on counter
  logic [31:0]   por_cnt_q, por_cnt_d;
  logic          por_q, por_d;

  // Conversion sequencer
  asc_state_type st_q, st_d;
  logic [31:0]   cnt_q, cnt_d;
  logic [31:0]   ph_q, ph_d;
  logic [31:0]   sph_q, sph_d;
  logic          armed_q, armed_d;
  logic          cont_q, cont_d;
  logic [2:0]    rate_q, rate_d;
  logic          stby_q, stby_d;
  logic          strobe_q, strobe_d;
  logic          dlow_q, dlow_d;
  logic          int_rst;
  logic          sync_evt;
  logic          cmd_is;
  logic          conv_q, conv_d;
  logic          setl_q, setl_d;

  // Two-stage pin synchronisers, edge taken from second stage
  always_comb begin
    meta_d      = {supply_a_ok & supply_d_ok, link.power_down_pin_n,
                   link.reset_pin_n, link.sync_pin};
    pin_d       = meta_q;
    sync_prev_d = pin_q[0];
    sync_rise   = pin_q[0] & ~sync_prev_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q      <= ASC_PIN_IDLE;
      pin_q       <= ASC_PIN_IDLE;
      sync_prev_q <= 1'b0;
    end else begin
      meta_q      <= meta_d;
      pin_q       <= pin_d;
      sync_prev_q <= sync_prev_d;
    end
  end

  // Global internal reset released after the supplies stay good for the count
  always_comb begin
    por_cnt_d = por_cnt_q;
    por_d     = por_q;
    if (!pin_q[3]) begin
      por_cnt_d = 32'h0;
      por_d     = 1'b1;
    end else if (por_q) begin
      if (por_cnt_q >= 32'(POR_CYC - 1)) begin
        por_d = 1'b0;
      end else begin
        por_cnt_d = por_cnt_q + 32'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      por_cnt_q <= 32'h0;
      por_q     <= 1'b1;
    end else begin
      por_cnt_q <= por_cnt_d;
      por_q     <= por_d;
    end
  end

  // Conversion sequencing: reset, standby, wake-up, sync and data ready
  always_comb begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    ph_d     = asc_wrap(ph_q, DATA_PERIOD_CYC);
    sph_d    = asc_wrap(sph_q, DATA_PERIOD_CYC);
    armed_d  = armed_q;
    cont_d   = cont_q;
    rate_d   = rate_q;
    stby_d   = stby_q;
    strobe_d = (ph_d >= STROBE_HI);
    dlow_d   = dlow_q;
    cmd_is   = link.cmd_valid;
    int_rst  = por_q | ~pin_q[1] | ~pin_q[2] |
               (cmd_is && link.cmd_code == CMD_RESET);
    sync_evt = sync_rise | (cmd_is && link.cmd_code == CMD_SYNC);
    if (int_rst) begin
      // Defaults restored and delay reloaded while held in reset
      cont_d   = 1'b0;
      rate_d   = ASC_RATE_CODE_DFLT;
      stby_d   = 1'b0;
      armed_d  = 1'b0;
      st_d     = ST_SETTLE;
      cnt_d    = RST_DLY;
      ph_d     = 32'h0;
      sph_d    = 32'h0;
      strobe_d = 1'b1;
      dlow_d   = 1'b1;
    end else if (cmd_is && link.cmd_code == CMD_STANDBY) begin
      st_d     = ST_OFF;
      stby_d   = 1'b1;
      strobe_d = 1'b1;
      dlow_d   = 1'b1;
    end else if (st_q == ST_OFF) begin
      strobe_d = 1'b1;
      if (cmd_is && link.cmd_code == CMD_WAKEUP) begin
        st_d   = ST_SETTLE;
        cnt_d  = WAKE_DLY;
        stby_d = 1'b0;
        ph_d   = 32'h0;
      end else if (cmd_is && link.cmd_code == CMD_CONT_MODE) begin
        cont_d  = 1'b1;
        armed_d = 1'b0;
      end else if (cmd_is && link.cmd_code == CMD_PULSE_MODE) begin
        cont_d = 1'b0;
      end
    end else if (cmd_is && link.cmd_code == CMD_CONT_MODE) begin
      cont_d  = 1'b1;
      armed_d = 1'b0;
    end else if (cmd_is && link.cmd_code == CMD_PULSE_MODE) begin
      cont_d = 1'b0;
    end else if (sync_evt && !cont_q) begin
      // Pulse sync: restart filter, strobe parked high
      st_d     = ST_SETTLE;
      cnt_d    = SYNC_DLY;
      ph_d     = 32'h0;
      strobe_d = 1'b1;
      dlow_d   = 1'b1;
    end else if (sync_evt && (!armed_q || sph_q != 32'h0)) begin
      // Continuous sync: first edge or period mismatch restarts filter
      st_d    = ST_SETTLE;
      cnt_d   = SYNC_DLY;
      armed_d = 1'b1;
      // Counter starts at one, so an edge whole periods later finds zero
      sph_d   = asc_wrap(32'h0, DATA_PERIOD_CYC);
      dlow_d  = 1'b1;
    end else begin
      // Matched edge realigns the period counter, settling keeps counting
      if (sync_evt) begin
        sph_d = asc_wrap(32'h0, DATA_PERIOD_CYC);
      end
      if (st_q == ST_SETTLE) begin
        // Strobe high in pulse mode, and always just before its first fall
        if (!cont_q || cnt_q == 32'h1) begin
          strobe_d = 1'b1;
        end
        if (cnt_q == 32'h0) begin
          // Filter settled: first strobe fall sets the phase
          st_d     = ST_RUN;
          ph_d     = 32'h0;
          strobe_d = 1'b0;
          dlow_d   = 1'b0;
        end else begin
          cnt_d = cnt_q - 32'h1;
        end
      end
    end
    conv_d = (st_d == ST_RUN);
    setl_d = (st_d == ST_SETTLE);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q     <= ST_SETTLE;
      cnt_q    <= 32'h0;
      ph_q     <= 32'h0;
      sph_q    <= 32'h0;
      armed_q  <= 1'b0;
      cont_q   <= 1'b0;
      rate_q   <= ASC_RATE_CODE_DFLT;
      stby_q   <= 1'b0;
      strobe_q <= 1'b1;
      dlow_q   <= 1'b1;
      conv_q   <= 1'b0;
      setl_q   <= 1'b1;
    end else begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      ph_q     <= ph_d;
      sph_q    <= sph_d;
      armed_q  <= armed_d;
      cont_q   <= cont_d;
      rate_q   <= rate_d;
      stby_q   <= stby_d;
      strobe_q <= strobe_d;
      dlow_q   <= dlow_d;
      conv_q   <= conv_d;
      setl_q   <= setl_d;
    end
  end

  // Outputs straight from flip-flops, driven in every state
  assign link.data_ready_strobe_n = strobe_q;
  assign link.dout_forced_low     = dlow_q;
  assign converting               = conv_q;
  assign settling                 = setl_q;
  assign standby                  = stby_q;
  assign cont_mode                = cont_q;
  assign rate_code                = rate_q;
  assign por_busy                 = por_q;
endmodule : asc_device
`default_nettype wire

// File: asc_host.sv
`timescale 1ns/1ps
`default_nettype none
module asc_host
  import asc_pkg::*;
#(
  parameter int unsigned SYNC_PERIOD_CYC = ASC_DATA_PERIOD_CYC
) (
  input  wire logic        clk,          // Master clock
  input  wire logic        rst_n,        // Synchronous reset, active low
  asc_if.host              link,         // Pins and commands to device
  input  wire logic        sync_req,     // Request one sync pulse
  input  wire logic        sync_clk_en,  // Run periodic sync clock
  input  wire logic        reset_req,    // Request a reset pin pulse
  input  wire logic        power_down,   // Hold power-down pin low
  input  wire logic        cmd_req,      // Send a command
  input  wire asc_cmd_type cmd_sel,      // Command to send
  output logic             new_data,     // Valid data ready, one cycle
  output logic             cont_cfg      // Continuous mode configured
);
  localparam logic [31:0] HALF_CYC = 32'(SYNC_PERIOD_CYC / 2);
  localparam logic [31:0] SYNC_HI  = 32'(ASC_SYNC_MIN_CYC - 1);
  localparam logic [31:0] RST_LO   = 32'(ASC_RESET_MIN_CYC - 1);

  logic [1:0]  meta_q, meta_d;
  logic [1:0]  seen_q, seen_d;
  logic        strobe_prev_q, strobe_prev_d;
  logic        nd_q, nd_d;
  logic        sync_q, sync_d;
  logic [31:0] scnt_q, scnt_d;
  logic        rst_pin_q, rst_pin_d;
  logic [31:0] rcnt_q, rcnt_d;
  logic        pdn_q, pdn_d;
  logic        cv_q, cv_d;
  asc_cmd_type code_q, code_d;
  logic        cfg_q, cfg_d;

  // Pin drive: sync pulse or clock, reset pulse, power-down, commands
  always_comb begin
    meta_d        = {link.dout_forced_low, link.data_ready_strobe_n};
    seen_d        = meta_q;
    strobe_prev_d = seen_q[0];
    nd_d          = strobe_prev_q & ~seen_q[0] & ~seen_q[1];
    sync_d        = sync_q;
    scnt_d        = (scnt_q == 32'h0) ? 32'h0 : scnt_q - 32'h1;
    rst_pin_d     = rst_pin_q;
    rcnt_d        = (rcnt_q == 32'h0) ? 32'h0 : rcnt_q - 32'h1;
    pdn_d         = ~power_down;
    cv_d          = cmd_req;
    code_d        = cmd_req ? cmd_sel : code_q;
    cfg_d         = cfg_q;
    if (cmd_req && cmd_sel == CMD_CONT_MODE) begin
      cfg_d = 1'b1;
    end else if ((cmd_req && (cmd_sel == CMD_PULSE_MODE || cmd_sel == CMD_RESET)) ||
                 power_down || !rst_pin_q) begin
      cfg_d = 1'b0;
    end
    if (scnt_q == 32'h0) begin
      if (sync_q) begin
        sync_d = 1'b0;
        scnt_d = (sync_clk_en && cfg_q) ? HALF_CYC - 32'h1 : SYNC_HI;
      end else if ((sync_clk_en && cfg_q) || sync_req) begin
        sync_d = 1'b1;
        scnt_d = (sync_clk_en && cfg_q) ? HALF_CYC - 32'h1 : SYNC_HI;
      end
    end
    if (!rst_pin_q) begin
      if (rcnt_q == 32'h0) begin
        rst_pin_d = 1'b1;
      end
    end else if (reset_req) begin
      rst_pin_d = 1'b0;
      rcnt_d    = RST_LO;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q        <= 2'h3;
      seen_q        <= 2'h3;
      strobe_prev_q <= 1'b1;
      nd_q          <= 1'b0;
      sync_q        <= 1'b0;
      scnt_q        <= 32'h0;
      rst_pin_q     <= 1'b1;
      rcnt_q        <= 32'h0;
      pdn_q         <= 1'b1;
      cv_q          <= 1'b0;
      code_q        <= CMD_SYNC;
      cfg_q         <= 1'b0;
    end else begin
      meta_q        <= meta_d;
      seen_q        <= seen_d;
      strobe_prev_q <= strobe_prev_d;
      nd_q          <= nd_d;
      sync_q        <= sync_d;
      scnt_q        <= scnt_d;
      rst_pin_q     <= rst_pin_d;
      rcnt_q        <= rcnt_d;
      pdn_q         <= pdn_d;
      cv_q          <= cv_d;
      code_q        <= code_d;
      cfg_q         <= cfg_d;
    end
  end

  assign link.sync_pin         = sync_q;
  assign link.reset_pin_n      = rst_pin_q;
  assign link.power_down_pin_n = pdn_q;
  assign link.cmd_valid        = cv_q;
  assign link.cmd_code         = code_q;
  assign new_data              = nd_q;
  assign cont_cfg              = cfg_q;
endmodule : asc_host
`default_nettype wire

// File: asc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface asc_if;
  import asc_pkg::*;
  logic        sync_pin;             // Sync input, rising edge acts
  logic        reset_pin_n;          // Reset pin, low resets
  logic        power_down_pin_n;     // Power-down pin, low powers down
  logic        cmd_valid;            // Decoded command, one cycle
  asc_cmd_type cmd_code;             // Command opcode
  logic        data_ready_strobe_n;  // Low when new data ready
  logic        dout_forced_low;      // Serial data held low

  modport dev (input sync_pin, reset_pin_n, power_down_pin_n, cmd_valid, cmd_code,
               output data_ready_strobe_n, dout_forced_low);
  modport host (output sync_pin, reset_pin_n, power_down_pin_n, cmd_valid, cmd_code,
                input data_ready_strobe_n, dout_forced_low);
endinterface : asc_if
`default_nettype wire

// File: asc_pkg.sv
`default_nettype none
package asc_pkg;
  // Master clock
  localparam int unsigned ASC_CLK_HZ          = 40_000_000;
  localparam int unsigned ASC_CLK_PERIOD_NS   = 25;
  // Default output rate after power-on or power-down release
  localparam int unsigned ASC_RATE_SPS        = 1000;
  localparam logic [2:0]  ASC_RATE_CODE_DFLT  = 3'h2;
  localparam int unsigned ASC_DATA_PERIOD_CYC = ASC_CLK_HZ / ASC_RATE_SPS;
  // Settling delay: 62.98046875 periods = 16123/256 periods
  localparam int unsigned ASC_FIR_NUM         = 16123;
  localparam int unsigned ASC_FIR_DEN         = 256;
  localparam int unsigned ASC_SYNC_EXTRA_CYC  = 466;
  localparam int unsigned ASC_RST_EXTRA_CYC   = 468;
  localparam int unsigned ASC_WAKE_SHORT_CYC  = 2;
  localparam int unsigned ASC_FILTER_READINGS = 63;
  // Power-on counter, 2^16 master-clock cycles
  localparam int unsigned ASC_POR_CYC         = 65536;
  // Strobe stays high this long before each new sample
  localparam int unsigned ASC_UPDATE_CYC      = 4;
  // Least pin phase widths driven by the host
  localparam int unsigned ASC_SYNC_MIN_CYC    = 2;
  localparam int unsigned ASC_RESET_MIN_CYC   = 2;
  // Synchroniser idle value {supply, power_down_n, reset_n, sync}
  localparam logic [3:0]  ASC_PIN_IDLE        = 4'h6;

  typedef enum logic [2:0] {
    CMD_SYNC, CMD_RESET, CMD_STANDBY, CMD_WAKEUP, CMD_CONT_MODE, CMD_PULSE_MODE
  } asc_cmd_type;

  typedef enum logic [1:0] {ST_OFF, ST_SETTLE, ST_RUN} asc_state_type;

  // Cycles from a restart edge to the first strobe fall, minus one
  function automatic logic [31:0] asc_dr_cyc(input int unsigned period,
                                             input int unsigned extra);
    asc_dr_cyc = 32'((period * ASC_FIR_NUM) / ASC_FIR_DEN + extra - 1);
  endfunction : asc_dr_cyc

  // Modulo increment of a period counter
  function automatic logic [31:0] asc_wrap(input logic [31:0] v,
                                           input int unsigned period);
    asc_wrap = (v >= 32'(period - 1)) ? 32'h0 : v + 32'h1;
  endfunction : asc_wrap
endpackage : asc_pkg
`default_nettype wire

// File: asc_test.sv
`timescale 1ns/1ps
`default_nettype none
module asc_test;
  import asc_pkg::*;
  localparam int P   = 64;
  localparam int POR = 16;
  localparam int FIR = P * 16123 / 256;
  typedef struct packed {
    asc_cmd_type cmd;    // Command sent
    logic [9:0]  extra;  // Settling extra cycles, zero if no restart
    logic        cont;   // Expected continuous mode
    logic        stby;   // Expected standby
  } asc_row_type;
  logic        clk, rst_n, sync_req, sync_clk_en, reset_req, power_down, cmd_req;
  logic        supply_a_ok, supply_d_ok, converting, settling, standby, cont_mode;
  logic        por_busy, new_data, cont_cfg;
  logic [2:0]  rate_code;
  asc_cmd_type cmd_sel;
  int          error_cnt, checks, n, rst_d, wake_d;
  asc_row_type rows [7] = '{'{CMD_CONT_MODE, 10'd0, 1'b1, 1'b0},
    '{CMD_RESET, 10'd468, 1'b0, 1'b0}, '{CMD_CONT_MODE, 10'd0, 1'b1, 1'b0},
    '{CMD_STANDBY, 10'd0, 1'b1, 1'b1}, '{CMD_PULSE_MODE, 10'd0, 1'b0, 1'b1},
    '{CMD_WAKEUP, 10'd466, 1'b0, 1'b0}, '{CMD_SYNC, 10'd466, 1'b0, 1'b0}};

  asc_if link_if ();
  asc_device #(.DATA_PERIOD_CYC(P), .POR_CYC(POR)) asc_device_inst (.clk(clk), .rst_n(rst_n),
    .link(link_if), .supply_a_ok(supply_a_ok), .supply_d_ok(supply_d_ok),
    .converting(converting), .settling(settling), .standby(standby), .cont_mode(cont_mode),
    .rate_code(rate_code), .por_busy(por_busy));
  asc_host #(.SYNC_PERIOD_CYC(P)) asc_host_inst (.clk(clk), .rst_n(rst_n), .link(link_if),
    .sync_req(sync_req), .sync_clk_en(sync_clk_en), .reset_req(reset_req),
    .power_down(power_down), .cmd_req(cmd_req), .cmd_sel(cmd_sel), .new_data(new_data),
    .cont_cfg(cont_cfg));
  asc_asserts #(.DATA_PERIOD_CYC(P)) asc_asserts_inst (.clk(clk), .rst_n(rst_n),
    .sync_pin(link_if.sync_pin), .reset_pin_n(link_if.reset_pin_n),
    .power_down_pin_n(link_if.power_down_pin_n), .cmd_valid(link_if.cmd_valid),
    .cmd_code(link_if.cmd_code), .data_ready_strobe_n(link_if.data_ready_strobe_n),
    .dout_forced_low(link_if.dout_forced_low));

  // Master clock
  always #12.5 clk = ~clk;

  task automatic chk_bit(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask : chk_bit

  task automatic chk_rng(input int got, input int lo, input int hi, input string what);
    checks++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s took %0d", $time, what, got);
    end
  endtask : chk_rng

  task automatic finish_test;
    $display("error_cnt=%0d checks=%0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc

  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(1);
  endtask : pulse

  task automatic send(input asc_cmd_type c);
    cmd_sel = c;
    pulse(cmd_req);
  endtask : send

  // Wait for the next valid sample, counting cycles
  task automatic wait_data(output int c);
    c = 0;
    while (new_data !== 1'b1) begin
      cyc(1);
      c++;
      if (c > 20000) begin
        error_cnt++;
        $display("CHECK FAILED at %0t: no new data", $time);
        finish_test();
      end
    end
    cyc(1);
  endtask : wait_data

  // Count cycles with the strobe low over a span
  task automatic low_cnt(input int span, output int c);
    c = 0;
    repeat (span) begin
      cyc(1);
      if (link_if.data_ready_strobe_n === 1'b0) c++;
    end
  endtask : low_cnt

  initial begin
    {clk, rst_n, sync_req, sync_clk_en, reset_req, power_down, cmd_req} = '0;
    {supply_a_ok, supply_d_ok, error_cnt, checks, rst_d, wake_d} = '0;
    supply_a_ok = 1'b1;
    supply_d_ok = 1'b1;
    cmd_sel = CMD_SYNC;
    cyc(8);
    chk_bit(link_if.data_ready_strobe_n && link_if.dout_forced_low, 1'b1, "reset idle");
    chk_bit(rate_code === ASC_RATE_CODE_DFLT, 1'b1, "default rate");
    rst_n = 1'b1;
    wait_data(n);
    chk_rng(n, POR + FIR + 468, POR + FIR + 478, "power-on");
    foreach (rows[i]) begin
      send(rows[i].cmd);
      cyc(2);
      chk_bit(cont_mode, rows[i].cont, "mode");
      chk_bit(standby, rows[i].stby, "standby");
      if (rows[i].extra != 10'd0) begin
        chk_bit(link_if.dout_forced_low, 1'b1, "data not held");
        wait_data(n);
        chk_rng(n, FIR + int'(rows[i].extra) - 4, FIR + int'(rows[i].extra) + 6, "cmd");
        if (rows[i].cmd == CMD_RESET) rst_d = n;
        if (rows[i].cmd == CMD_WAKEUP) wake_d = n;
      end
    end
    chk_rng(rst_d - wake_d, 2, 3, "wake-up gap");
    pulse(sync_req);
    cyc(6);
    chk_bit(settling && link_if.dout_forced_low, 1'b1, "pulse sync");
    wait_data(n);
    chk_rng(n + 8, FIR + 466, FIR + 474, "pulse sync");
    chk_bit(converting, 1'b1, "converting");
    send(CMD_CONT_MODE);
    chk_bit(cont_cfg, 1'b1, "host mode");
    wait_data(n);
    pulse(sync_req);
    low_cnt(3 * P, n);
    chk_rng(n, 3 * P - 16, 3 * P - 8, "strobe toggling");
    chk_bit(link_if.dout_forced_low, 1'b1, "data low");
    wait_data(n);
    chk_rng(n + 3 * P + 2, FIR + 466, FIR + 474, "cont sync");
    send(CMD_CONT_MODE);
    sync_clk_en = 1'b1;
    cyc(P + 6);
    chk_bit(link_if.dout_forced_low, 1'b1, "first clock edge");
    wait_data(n);
    chk_rng(n + P + 6, FIR + 466, FIR + 474 + P, "clock sync");
    n = 0;
    repeat (4 * P) begin
      cyc(1);
      if (link_if.dout_forced_low !== 1'b0) n++;
    end
    chk_rng(n, 0, 0, "matched clock");
    sync_clk_en = 1'b0;
    cyc(P);
    send(CMD_STANDBY);
    pulse(sync_req);
    low_cnt(2 * P, n);
    chk_rng(n, 0, 0, "standby strobe");
    chk_bit(settling, 1'b0, "standby sync");
    send(CMD_WAKEUP);
    wait_data(n);
    pulse(reset_req);
    cyc(6);
    chk_bit(link_if.dout_forced_low, 1'b1, "reset pin");
    wait_data(n);
    chk_rng(n + 8, FIR + 468, FIR + 478, "reset pin");
    send(CMD_CONT_MODE);
    power_down = 1'b1;
    cyc(40);
    chk_bit(link_if.data_ready_strobe_n && !cont_mode, 1'b1, "power-down");
    chk_bit(rate_code === ASC_RATE_CODE_DFLT, 1'b1, "default rate");
    power_down = 1'b0;
    wait_data(n);
    chk_rng(n, FIR + 468, FIR + 478, "power-down release");
    for (int i = 0; i < 2; i++) begin
      {supply_a_ok, supply_d_ok} = (i == 0) ? 2'b01 : 2'b10;
      cyc(5);
      chk_bit(por_busy, 1'b1, "supply low");
      {supply_a_ok, supply_d_ok} = 2'b11;
      n = 0;
      while (por_busy === 1'b1 && n < 1000) begin
        cyc(1);
        n++;
      end
      chk_rng(n, POR, POR + 4, "power-on count");
      wait_data(n);
    end
    finish_test();
  end
endmodule : asc_test
`default_nettype wire
